/* File: adc_front_end.sv */
`timescale 1ns/1ps
// input mux and comparator: decides input >= trial code
module adc_front_end (
    input wire clk,
    input wire [4:0] mux_select,
    input wire [7:0] dac_code,
    input wire converter_power,
    input wire [31:0] levels,
    output reg comparator_high
);
    reg wobble_r = 1'b0;
    // an unpowered or unused input gives no stable decision
    always @(posedge clk) wobble_r <= ~wobble_r;
    // references saturate the result at either end of the scale
    always @* begin
        if (!converter_power) comparator_high = wobble_r;
        else if (mux_select == 5'h1D) comparator_high = 1'b1;
        else if (mux_select == 5'h1E) comparator_high = dac_code == 8'h00;
        else if (mux_select < 5'h04)
            comparator_high = levels[mux_select[1:0] * 8 +: 8] >= dac_code;
        else comparator_high = wobble_r;
    end
endmodule // adc_front_end

/* File: sar_adc_defs.vh */
// Summary of operation
// - a status/control write starts a conversion; it ends in 16 to 17 converter clocks.
// - one converter gives an 8-bit result from one of four muxed channels.
// - at the end, load the result, then set the done flag or raise the interrupt.
// - the selected pin is forced to input; port and direction writes do not reach it.
// - a read of a claimed pin gives 0 when direction is 0, latch when 1.
// - high reference reads 0xFF, ground 0x00, linear between, saturating outside.
// - continuous mode rewrites the result every conversion, read or not.
// - continuous mode restarts conversions until software clears the continuous bit.
// - continuous done flag stays set until a control write or result read.
// - with interrupts on, irq when done flag is 0, dma request when 1.
// - with interrupts enabled the done flag is not a completion indication.
// - conversions run on in wait mode; their interrupt can wake the processor.
// - stop mode aborts any conversion; conversions resume after stop (the code stays idle until a new control write).
// - channel select all ones powers the converter off; reset sets it.
// - without continuous mode, exactly one conversion per start.
// - result read or control write clears the conversion interrupt.
// - a 3-bit prescale divides the input clock by 1, 2, 4, 8 or 16.
`ifndef SAR_ADC_DEFS_VH
`define SAR_ADC_DEFS_VH
`define ADDR_W 8
`define OFF_STATUS_CONTROL 8'h3C
`define OFF_RESULT 8'h3D
`define OFF_CLOCK 8'h3E
`define OFF_PORT_DATA 8'h3F
`define OFF_PORT_DIR 8'h40
`define BIT_DONE 7
`define BIT_IRQ_EN 6
`define BIT_CONT 5
`define CHSEL_OFF 5'h1F
`define CHSEL_HIGH_REFERENCE 5'h1D
`define CHSEL_VSS 5'h1E
`define CHSEL_RESET 5'h1F
`define NUM_PINS 4
`define RESULT_W 8
`define SAMPLE_TICKS 5'h08
`define STEP_LAST 5'h10
`define STEPS_W 5
`define DIV_W 4
`define ZERO8 8'h00
`define FULL8 8'hFF
`define PRESCALE_RESET 3'h0
`define STEP_ZERO 5'h00
`define STEP_ONE 5'h01
`define BIT_TOP 3'h7
`define BIT_ZERO 3'h0
`define BIT_ONE 3'h1
`define SAR_TRIAL 8'h80
`define CHSEL_MSB 4
`define DIV_ZERO 4'h0
`define DIV_ONE 4'h1
`define PRESC_MSB 7
`define PRESC_LSB 5
`define BIT_CLK_SEL 4
`define PORT_MSB 3
`endif

/* File: sar_adc_sequencer.v */
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`include "sar_adc_defs.vh"
// converter control: register port, port-pin override, sar sequencing
// the register port never stalls: writes land on the strobe edge and
// read data stand for exactly one cycle after the read strobe
// limitation: changing the prescale or clock source mid-conversion
// gives a wrong conversion time; software should change them while idle
// the trial code is registered, so every decision sees a settled code
// at the comparator for a full converter clock
module sar_adc_sequencer (
    // register port
    input wire clk,
    input wire reset,
    input wire [7:0] addr,
    input wire [7:0] wr_data,
    input wire wr_strobe,
    input wire rd_strobe,
    output reg [7:0] rd_data,
    // converter input clock sources
    input wire clock_source_bus,
    input wire osc_tick,
    // analog multiplexer and comparator
    input wire comparator_high,
    output reg [7:0] dac_code,
    output wire [4:0] mux_select,
    output wire converter_power,
    // shared port pins, pin side
    input wire [3:0] shared_port_pins_in,
    output wire [3:0] shared_port_pins_out,
    output wire [3:0] shared_port_pins_oe,
    // low-power mode and requests
    input wire stop_mode,
    output wire conversion_irq,
    output wire dma_request
);
    // sequencer states, one-hot
    localparam ST_IDLE = 3'b001;
    localparam ST_SAMPLE = 3'b010;
    localparam ST_BITS = 3'b100;

    // software-visible control and status fields
    reg [7:0] result_r;
    reg done_r;
    reg irq_en_r;
    reg cont_r;
    reg [4:0] chsel_r;

    // clock register fields
    reg [2:0] prescale_r;
    reg clk_sel_r;

    // port latch and direction for the shared pins
    reg [3:0] port_data_r;
    reg [3:0] port_dir_r;

    // completion requests towards the processor
    reg irq_r;
    reg dma_r;

    // sequencer state, prescaler and approximation register
    reg [2:0] state_r;
    reg [3:0] div_cnt_r;
    reg [4:0] step_r;
    reg [7:0] sar_r;
    reg [7:0] sar_nxt;
    reg [2:0] bit_idx_r;

    // register decodes and converter status
    wire ctrl_wr;
    wire result_rd;
    wire powered;
    wire in_tick;
    wire adc_tick;
    wire [3:0] div_limit;
    wire [3:0] claimed;
    wire finish;
    wire sample_done;

    // one register address decode, shared by the port and the strobes
    function hit;
        input [7:0] a;
        input [7:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    // divide ratio: codes 4..7 all mean divide by 16
    function [3:0] div_max;
        input [2:0] code;
        begin
            if (code[2])
                div_max = 4'hF;
            else
                div_max = (4'h1 << code[1:0]) - 4'h1;
        end
    endfunction

    // one-hot pin claim, nothing claimed for internal references
    function [3:0] pin_claim;
        input [4:0] sel;
        begin
            if (sel < `NUM_PINS)
                pin_claim = 4'h1 << sel[1:0];
            else
                pin_claim = 4'h0;
        end
    endfunction

    // port read value: a claimed input pin reads 0, an output its latch
    function [3:0] port_view;
        input [3:0] pins;
        input [3:0] claim;
        input [3:0] dir;
        input [3:0] latch;
        begin
            port_view = (pins & ~claim & ~dir) | (latch & dir);
        end
    endfunction

    // register strobes that move the sequencer
    assign ctrl_wr = wr_strobe && hit(addr, `OFF_STATUS_CONTROL);
    assign result_rd = rd_strobe && hit(addr, `OFF_RESULT);
    assign powered = (chsel_r != `CHSEL_OFF);

    // the bus clock ticks every edge; the oscillator tick is a strobe
    assign in_tick = clock_source_bus | osc_tick;
    assign div_limit = div_max(prescale_r);
    assign adc_tick = in_tick && (div_cnt_r == div_limit);

    // end of sampling and end of conversion, one tick each
    assign sample_done = (state_r == ST_SAMPLE) && adc_tick &&
        (step_r + `STEP_ONE == `SAMPLE_TICKS);
    // stop gates the end so an aborted run never reports completion
    assign finish = (state_r == ST_BITS) && adc_tick && !stop_mode &&
        (step_r == `STEP_LAST);

    // pin claim and the analog side
    assign claimed = pin_claim(chsel_r);
    assign mux_select = chsel_r;
    assign converter_power = powered && !stop_mode;
    assign conversion_irq = irq_r;
    assign dma_request = dma_r;

    // claimed pins are inputs only; latch writes never show on them
    assign shared_port_pins_oe = port_dir_r & ~claimed;
    assign shared_port_pins_out = port_data_r & ~claimed;

    // prescaler counter; restarted with each conversion for a clean 16-17
    // idle holds it at zero so the first tick falls a full period late
    always @(posedge clk) begin
        if (reset || ctrl_wr || state_r == ST_IDLE)
            div_cnt_r <= `DIV_ZERO;
        else if (adc_tick)
            div_cnt_r <= `DIV_ZERO;
        else if (in_tick)
            div_cnt_r <= div_cnt_r + `DIV_ONE;
    end

    // sequencer: 8 sampling clocks, then one bit per clock and one end clock, 17 total
    always @(posedge clk) begin
        if (reset || stop_mode) begin
            // stop aborts the run; a fresh write is needed afterwards
            state_r <= ST_IDLE;
            step_r <= `STEP_ZERO;
            bit_idx_r <= `BIT_TOP;
        end else if (ctrl_wr) begin
            // restart on the new channel, abort whatever was running
            if (wr_data[`CHSEL_MSB:0] != `CHSEL_OFF)
                state_r <= ST_SAMPLE;
            else
                state_r <= ST_IDLE;
            step_r <= `STEP_ZERO;
            bit_idx_r <= `BIT_TOP;
        end else begin
            // idle holds the counters ready for the next start
            case (state_r)
                ST_IDLE: begin
                    step_r <= `STEP_ZERO;
                    bit_idx_r <= `BIT_TOP;
                end
                ST_SAMPLE: begin
                    // the input settles on the sampling capacitor
                    if (adc_tick)
                        step_r <= step_r + `STEP_ONE;
                    if (sample_done)
                        state_r <= ST_BITS;
                end
                ST_BITS: begin
                    if (finish) begin
                        // continuous runs back to back; single stops
                        if (cont_r)
                            state_r <= ST_SAMPLE;
                        else
                            state_r <= ST_IDLE;
                        step_r <= `STEP_ZERO;
                        bit_idx_r <= `BIT_TOP;
                    end else if (adc_tick) begin
                        // one decision per tick, msb first
                        step_r <= step_r + `STEP_ONE;
                        if (bit_idx_r != `BIT_ZERO)
                            bit_idx_r <= bit_idx_r - `BIT_ONE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                    step_r <= `STEP_ZERO;
                    bit_idx_r <= `BIT_TOP;
                end
            endcase
        end
    end

    // next trial code; a write or stop clears it for a clean start
    // references need no special code: the comparator saturates them
    always @* begin
        sar_nxt = sar_r;
        if (ctrl_wr || stop_mode)
            sar_nxt = `ZERO8;
        else if (sample_done)
            sar_nxt = `SAR_TRIAL;
        else if ((state_r == ST_BITS) && adc_tick && !finish) begin
            // keep or drop the trial bit, then try the next one down
            if (!comparator_high)
                sar_nxt[bit_idx_r] = 1'b0;
            if (bit_idx_r != `BIT_ZERO)
                sar_nxt[bit_idx_r - `BIT_ONE] = 1'b1;
        end
    end

    // approximation register and the code the comparator is shown;
    // both load the same next value so a decision sees a settled code
    always @(posedge clk) begin
        if (reset) begin
            sar_r <= `ZERO8;
            dac_code <= `ZERO8;
        end else begin
            sar_r <= sar_nxt;
            dac_code <= sar_nxt;
        end
    end

    // control fields; a write also clears the flag and requests below
    always @(posedge clk) begin
        if (reset) begin
            irq_en_r <= 1'b0;
            cont_r <= 1'b0;
            chsel_r <= `CHSEL_RESET;
        end else if (ctrl_wr) begin
            irq_en_r <= wr_data[`BIT_IRQ_EN];
            cont_r <= wr_data[`BIT_CONT];
            chsel_r <= wr_data[`CHSEL_MSB:0];
        end
    end

    // result register; continuous mode overwrites unread results
    always @(posedge clk) begin
        if (reset)
            result_r <= `ZERO8;
        else if (finish)
            result_r <= sar_r;
    end

    // done flag; a finishing conversion beats a same-cycle clear
    // with interrupts on it is never set, so it marks nothing there
    always @(posedge clk) begin
        if (reset)
            done_r <= 1'b0;
        else if (finish && !irq_en_r)
            done_r <= 1'b1;
        else if (ctrl_wr || result_rd)
            done_r <= 1'b0;
    end

    // completion requests; with interrupts on the flag is no completion
    // mark, it only steers the request to the dma line
    always @(posedge clk) begin
        if (reset) begin
            irq_r <= 1'b0;
            dma_r <= 1'b0;
        end else if (finish && irq_en_r) begin
            irq_r <= !done_r;
            dma_r <= done_r;
        end else if (ctrl_wr || result_rd) begin
            irq_r <= 1'b0;
            dma_r <= 1'b0;
        end
    end

    // clock and port registers; the clock select bit is only stored,
    // the clock_source_bus pin picks the input clock
    always @(posedge clk) begin
        if (reset) begin
            prescale_r <= `PRESCALE_RESET;
            clk_sel_r <= 1'b0;
            port_data_r <= 4'h0;
            port_dir_r <= 4'h0;
        end else if (wr_strobe) begin
            if (hit(addr, `OFF_CLOCK)) begin
                prescale_r <= wr_data[`PRESC_MSB:`PRESC_LSB];
                clk_sel_r <= wr_data[`BIT_CLK_SEL];
            end
            if (hit(addr, `OFF_PORT_DATA))
                port_data_r <= wr_data[`PORT_MSB:0];
            if (hit(addr, `OFF_PORT_DIR))
                port_dir_r <= wr_data[`PORT_MSB:0];
        end
    end

    // read mux; data valid the cycle after the strobe only, else zero
    always @(posedge clk) begin
        if (reset || !rd_strobe) begin
            rd_data <= `ZERO8;
        end else begin
            case (addr)
                `OFF_STATUS_CONTROL: begin
                    rd_data <= {done_r, irq_en_r, cont_r, chsel_r};
                end
                `OFF_RESULT: begin
                    rd_data <= result_r;
                end
                `OFF_CLOCK: begin
                    rd_data <= {prescale_r, clk_sel_r, 4'h0};
                end
                `OFF_PORT_DATA: begin
                    rd_data <= {4'h0, port_view(shared_port_pins_in,
                        claimed, port_dir_r, port_data_r)};
                end
                `OFF_PORT_DIR: begin
                    rd_data <= {4'h0, port_dir_r};
                end
                default: begin
                    rd_data <= `ZERO8;
                end
            endcase
        end
    end
endmodule // sar_adc_sequencer

/* File: sar_adc_sequencer_assertions.sv */
`timescale 1ns/1ps
// pin-level checks on the converter control block
module sar_adc_sequencer_checker (
    input wire clk,
    input wire reset,
    input wire [7:0] addr,
    input wire [7:0] wr_data,
    input wire wr_strobe,
    input wire rd_strobe,
    input wire [4:0] mux_select,
    input wire converter_power,
    input wire [3:0] shared_port_pins_oe,
    input wire stop_mode,
    input wire conversion_irq,
    input wire dma_request
);
    // decoded causes; stop is allowed as a clear since it idles the block
    wire ctl_wr = wr_strobe && addr == 8'h3C;
    wire clr_cause = ctl_wr || (rd_strobe && addr == 8'h3D) || stop_mode;
    wire [4:0] new_chan = wr_data[4:0];
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    AST_CHAN_POWER: assert property (ctl_wr ##1 !stop_mode |->
        mux_select == $past(new_chan) && converter_power == (mux_select != 5'h1F))
        else $error("channel or power wrong after control write");
    AST_CLAIMED_PIN: assert property (
        (mux_select[4:2] == 3'h0) ##1 $stable(mux_select) |->
        !shared_port_pins_oe[mux_select[1:0]])
        else $error("claimed pin still driven");
    AST_NO_EARLY_END: assert property (ctl_wr |-> ##7
        (!$rose(conversion_irq) && !$rose(dma_request)) [*8])
        else $error("conversion ended too early");
    AST_IRQ_DMA_EXCL: assert property (
        !(conversion_irq && dma_request))
        else $error("irq and dma request together");
    AST_STOP_QUIET: assert property (stop_mode ##1 stop_mode |->
        !$rose(conversion_irq) && !$rose(dma_request))
        else $error("completion during stop");
    AST_IRQ_CLEAR: assert property ($fell(conversion_irq) |->
        $past(clr_cause))
        else $error("irq dropped without a clear");
    AST_DMA_CLEAR: assert property ($fell(dma_request) |->
        $past(clr_cause))
        else $error("dma request dropped without a clear");
    AST_OFF_IDLE: assert property ((!converter_power) [*2] |->
        !$rose(conversion_irq))
        else $error("completion while powered off");
endmodule // sar_adc_sequencer_checker
bind sar_adc_sequencer sar_adc_sequencer_checker chk (.clk, .reset, .addr,
    .wr_data, .wr_strobe, .rd_strobe, .mux_select, .converter_power,
    .shared_port_pins_oe, .stop_mode, .conversion_irq, .dma_request);

/* File: sar_adc_sequencer_bench.sv */
`timescale 1ns/1ps
// drives the register port; read answers are checked from a queue
module sar_adc_sequencer_bench;
    reg clk = 1'b0, reset = 1'b1, wr_strobe = 1'b0, rd_strobe = 1'b0;
    reg clock_source_bus = 1'b1, osc_tick = 1'b0, stop_mode = 1'b0;
    reg rd_seen_r = 1'b0;
    reg [7:0] addr = 8'h00, wr_data = 8'h00, lvl;
    reg [3:0] pin_ext = 4'h0;
    reg [31:0] levels = 32'h0000_0000;
    wire [7:0] rd_data, dac_code;
    wire [4:0] mux_select;
    wire [3:0] pins_in, pins_out, pins_oe;
    wire comparator_high, converter_power, conversion_irq, dma_request;
    reg [7:0] exp_q[$];
    integer seed = 3, failures = 0, comparisons = 0, i, n;
    initial forever #2.5 clk = ~clk;
    // pin level: our pin drive unless the block drives it
    assign pins_in = (pins_oe & pins_out) | (~pins_oe & pin_ext);
    always @(posedge clk) osc_tick <= ~osc_tick;
    sar_adc_sequencer dut (.clk(clk), .reset(reset), .addr(addr),
        .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
        .rd_data(rd_data), .clock_source_bus(clock_source_bus),
        .osc_tick(osc_tick), .comparator_high(comparator_high),
        .dac_code(dac_code), .mux_select(mux_select),
        .converter_power(converter_power), .shared_port_pins_in(pins_in),
        .shared_port_pins_out(pins_out), .shared_port_pins_oe(pins_oe),
        .stop_mode(stop_mode), .conversion_irq(conversion_irq),
        .dma_request(dma_request));
    adc_front_end front (.clk(clk), .mux_select(mux_select),
        .dac_code(dac_code), .converter_power(converter_power),
        .levels(levels), .comparator_high(comparator_high));
    task print_verdict;
        begin
            $display("comparisons %0d failures %0d", comparisons, failures);
            if (failures == 0 && comparisons > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask
    task check(input [63:0] nm, input [15:0] e, input [15:0] g);
        begin
            comparisons = comparisons + 1;
            if (g !== e) begin
                failures = failures + 1;
                $display("MISMATCH %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    // read data stands only in the cycle after the strobe
    always @(posedge clk) begin
        rd_seen_r <= rd_strobe;
        if (rd_seen_r) check("rd_data", exp_q.pop_front(), rd_data);
    end
    task bus(input w, input r, input [7:0] a, input [7:0] d);
        begin
            wr_strobe <= w;
            rd_strobe <= r;
            addr <= a;
            wr_data <= d;
            @(posedge clk);
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            bus(1'b1, 1'b0, a, d);
            bus(1'b0, 1'b0, a, d);
        end
    endtask
    task rd(input [7:0] a, input [7:0] e);
        begin
            exp_q.push_back(e);
            bus(1'b0, 1'b1, a, 8'h00);
            bus(1'b0, 1'b0, a, 8'h00);
        end
    endtask
    // n counts edges from the start write to the visible interrupt
    task conv(input [7:0] d, input integer mul, input [7:0] e);
        begin
            wr(8'h3C, d);
            n = 1;
            while (n < 400 && conversion_irq !== 1'b1) begin
                @(negedge clk);
                n = n + 1;
            end
            if (n >= 400) begin
                failures = failures + 1;
                print_verdict;
            end
            check("time", 1, n >= 16 * mul && n <= 17 * mul + 1);
            @(posedge clk);
            rd(8'h3D, e);
        end
    endtask
    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        levels <= $random(seed);
        pin_ext <= $random(seed);
        check("power", 0, converter_power);
        rd(8'h3C, 8'h1F);
        rd(8'h55, 8'h00);
        wr(8'h3F, 8'h0A);
        wr(8'h40, 8'h0F);
        wr(8'h3C, 8'h01);
        @(negedge clk);
        check("pins_oe", 4'hD, pins_oe);
        @(posedge clk);
        rd(8'h3F, 8'h0A);
        wr(8'h40, 8'h0D);
        rd(8'h3F, 8'h08);
        // prescale codes 0 to 4 on a pin channel, then both references
        for (i = 0; i < 7; i = i + 1) begin
            clock_source_bus <= (i != 5);
            wr(8'h3E, {(i < 5) ? i[2:0] : 3'h0, 5'h10});
            lvl = (i == 5) ? 8'hFF : (i == 6) ? 8'h00 : levels[i%4*8 +: 8];
            conv({3'h2, (i < 5) ? {3'h0, i[1:0]} : 5'h18 + i[4:0]},
                (i < 5) ? 1 << i : 1 + (i == 5), lvl);
        end
        wr(8'h3C, 8'h40);
        repeat (6) @(posedge clk);
        conv(8'h43, 1, levels[31:24]);
        wr(8'h3C, 8'h02);
        repeat (30) @(posedge clk);
        rd(8'h3C, 8'h82);
        rd(8'h3D, levels[23:16]);
        rd(8'h3C, 8'h02);
        repeat (40) @(posedge clk);
        rd(8'h3C, 8'h02);
        wr(8'h3C, 8'h23);
        repeat (40) @(posedge clk);
        rd(8'h3C, 8'hA3);
        lvl = $random(seed);
        levels[31:24] <= lvl;
        repeat (40) @(posedge clk);
        rd(8'h3D, lvl);
        wr(8'h3C, 8'h41);
        repeat (5) @(posedge clk);
        stop_mode <= 1'b1;
        repeat (30) @(posedge clk);
        check("irq", 0, conversion_irq);
        stop_mode <= 1'b0;
        repeat (20) @(posedge clk); // settle time after stop
        conv(8'h41, 1, levels[15:8]);
        wr(8'h40, 8'h00);
        rd(8'h3F, {4'h0, pin_ext & 4'hD});
        wr(8'h3C, 8'h1F);
        @(negedge clk);
        check("power", 0, converter_power);
        print_verdict;
    end
endmodule // sar_adc_sequencer_bench
